// ### tpm_timer.sv
// tpm_timer: three-channel 16-bit timer with pwm and phase counting modes
// assumes a single 40 MHz clock, synchronous reset, phase inputs async
//
// Contract
// [R1] compare match drives its pin low, high or toggled per output select
// [R2] channels enter pwm alone; clear source match sets period; sync allowed
// [R3] pwm1 pairs A with B and C with D onto pins A and C
// [R4] pwm1 pin starts at the initial level of register A or C
// [R5] pwm1 pair holding equal values leaves the pin unchanged
// [R6] pwm1 gives at most four phases across the unit
// [R7] pwm2 cycle register pin gives no output; duty registers drive own pin
// [R8] pwm2 counter clear returns every pin to its initial level
// [R9] pwm2 duty equal to cycle causes no level change
// [R10] pwm2 with synchronous operation gives up to seven phases
// [R11] channel 0 has four registers and pins, channels 1 and 2 two
// [R12] phase counting is available on channels 1 and 2 only
// [R13] phase mode counts from phase inputs; other functions stay active
// [R14] overflow flag on up-count wrap, underflow flag on down-count wrap
// [R15] readable direction bit shows up or down counting
// [R16] channel 1 phases on inputs a and b, channel 2 on c and d
// [R17] four phase counting variants with different count conditions
// [R18] variant 1 counts on every edge of both phases
// [R19] variant 2 counts on phase A falling edges by phase B level
// [R20] variant 3: A falling with B high up, B falling with A high down
// [R21] variant 4 counts only on phase B edges by phase A level
// [R22] underflow request while flag and enable set, drops when flag cleared
// [R23] phase inputs synchronised and edges found from consecutive samples
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "tpm_defs.svh"

module tpm_timer
	import tpm_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input tpm_bus_req_t bus_req,
	output logic [`TPM_CW-1:0] rdata,
	input wire logic [3:0] ext_clock_in,
	output tpm_pins_t pins,
	output logic [2:0] ovf_irq,
	output logic [2:0] udf_irq
);

	tpm_state_t s;
	tpm_state_t n;
	tpm_mode_t [2:0] md;
	logic [2:0][1:0] ph;
	logic [2:0] up;
	logic [2:0] dn;
	logic [2:0] tick;
	logic [2:0] own_clr;
	logic [2:0] clr;
	logic [2:0][3:0] hit;
	logic sync_clr;
	logic [2:0] ch;
	logic [3:0] rs;
	logic [`TPM_CW-1:0] wd;
	logic [5:0] cm;
	logic [2:0] csel;
	logic cv;
	logic [1:0] cy;
	logic [1:0] ri;

	function automatic int nregs(input int c);
		return (c == 0) ? 4 : 2;
	endfunction : nregs

	function automatic logic apply_act(input logic cur, input logic [3:0] sel);
		case (sel[1:0])
		2'h1: return 1'b0;
		2'h2: return 1'b1;
		2'h3: return ~cur;
		default: return cur;
		endcase
	endfunction : apply_act

	// returns {up, down} for one sample step of the two phases
	function automatic logic [1:0] phase_step(
		input logic [1:0] v,
		input logic a,
		input logic b,
		input logic pa,
		input logic pb
	);
		logic ar;
		logic af;
		logic br;
		logic bf;
		ar = a & ~pa;
		af = ~a & pa;
		br = b & ~pb;
		bf = ~b & pb;
		case (v) // R17
		2'h0: begin // R18
			phase_step[1] = (br & a) | (bf & ~a) | (ar & ~b) | (af & b);
			phase_step[0] = (br & ~a) | (bf & a) | (ar & b) | (af & ~b);
		end
		2'h1: begin // R19
			phase_step[1] = af & b;
			phase_step[0] = af & ~b;
		end
		2'h2: begin // R20
			phase_step[1] = af & b;
			phase_step[0] = bf & a;
		end
		default: begin // R21
			phase_step[1] = (br & a) | (bf & ~a);
			phase_step[0] = (bf & a) | (br & ~a);
		end
		endcase
	endfunction : phase_step

	always_comb begin
		n = s;
		ch = bus_req.addr[6:4];
		rs = bus_req.addr[3:0];
		wd = bus_req.wdata;
		cm = 6'h00;
		csel = `TPM_CLR_NONE;
		cv = 1'b0;
		cy = 2'h0;
		ri = 2'h0;
		sync_clr = 1'b0;
		n.rdata = '0;
		// two-stage synchroniser, then one more stage for edge detection
		n.s1 = ext_clock_in; // R23
		n.s2 = s.s1;
		n.prev = s.s2;
		ph[0] = 2'h0;
		ph[1] = phase_step(s.ctrl[1][`TPM_F_PV], s.s2[0], s.s2[1],
			s.prev[0], s.prev[1]); // R16 R23
		ph[2] = phase_step(s.ctrl[2][`TPM_F_PV], s.s2[2], s.s2[3],
			s.prev[2], s.prev[3]); // R16 R23

		for (int c = 0; c < 3; c++) begin
			md[c] = tpm_mode_t'(s.ctrl[c][`TPM_F_MODE]);
			if (md[c] == TPM_PHASE) begin // R13
				up[c] = s.start[c] & ph[c][1];
				dn[c] = s.start[c] & ph[c][0];
			end else begin
				up[c] = s.start[c];
				dn[c] = 1'b0;
			end
			tick[c] = up[c] | dn[c];
			for (int k = 0; k < 4; k++) begin
				hit[c][k] = tick[c] && k < nregs(c) && s.cnt[c] == s.cmp[c][k];
			end
			csel = s.ctrl[c][`TPM_F_CLR];
			cv = csel >= 3'h1 && csel <= 3'h4;
			cy = 2'(csel - 3'h1);
			own_clr[c] = cv && hit[c][cy]; // R2
			if (own_clr[c] && s.sync[c])
				sync_clr = 1'b1;
		end

		for (int c = 0; c < 3; c++) begin
			csel = s.ctrl[c][`TPM_F_CLR];
			cv = csel >= 3'h1 && csel <= 3'h4;
			cy = 2'(csel - 3'h1);
			clr[c] = own_clr[c] ||
				(csel == `TPM_CLR_SYNC && s.sync[c] && sync_clr); // R2
			if (clr[c])
				n.cnt[c] = `TPM_CNT_ZERO;
			else if (up[c])
				n.cnt[c] = s.cnt[c] + 16'h0001;
			else if (dn[c])
				n.cnt[c] = s.cnt[c] - 16'h0001;
			if (up[c])
				n.dir[c] = 1'b1; // R15
			else if (dn[c])
				n.dir[c] = 1'b0; // R15

			// hardware set wins over a software clear in the same cycle
			cm = 6'h00;
			if (bus_req.wr && ch == 3'(c) && rs == `TPM_REG_STAT)
				cm = ~wd[5:0];
			n.flag[c] = s.flag[c] & ~cm; // R22
			n.flag[c][3:0] = n.flag[c][3:0] | hit[c];
			if (up[c] && s.cnt[c] == `TPM_CNT_MAX && !clr[c])
				n.flag[c][`TPM_F_OVF] = 1'b1; // R14
			if (dn[c] && s.cnt[c] == `TPM_CNT_ZERO && !clr[c])
				n.flag[c][`TPM_F_UDF] = 1'b1; // R14

			for (int k = 0; k < 4; k++) begin
				case (md[c])
				TPM_PWM1: begin
					if (k[0] == 1'b0 && k < nregs(c) &&
						s.cmp[c][k] != s.cmp[c][k | 1]) begin // R5
						if (hit[c][k])
							n.pins.level[c][k] = apply_act(s.pins.level[c][k],
								s.ioc[c][4*k +: 4]); // R3
						else if (hit[c][k | 1])
							n.pins.level[c][k] = apply_act(s.pins.level[c][k],
								s.ioc[c][4*(k | 1) +: 4]); // R3
					end
					n.pins.oe[c][k] = k[0] == 1'b0 && k < nregs(c); // R6 R11
				end
				TPM_PWM2: begin
					if (clr[c])
						n.pins.level[c][k] = s.ioc[c][4*k + `TPM_F_INIT]; // R8
					else if (hit[c][k] && !(cv && k == cy) &&
						!(cv && s.cmp[c][k] == s.cmp[c][cy]))
						n.pins.level[c][k] = apply_act(s.pins.level[c][k],
							s.ioc[c][4*k +: 4]); // R7 R9
					n.pins.oe[c][k] = k < nregs(c) && !(cv && k == cy); // R7 R10
				end
				default: begin
					if (hit[c][k])
						n.pins.level[c][k] = apply_act(s.pins.level[c][k],
							s.ioc[c][4*k +: 4]); // R1
					n.pins.oe[c][k] = k < nregs(c) &&
						s.ioc[c][4*k +: 2] != 2'h0; // R11
				end
				endcase
			end

			if (bus_req.wr && ch == 3'(c)) begin
				case (rs)
				`TPM_REG_CTRL: begin
					n.ctrl[c] = wd[7:0];
					if (c == 0 && wd[1:0] == 2'h3)
						n.ctrl[c][`TPM_F_MODE] = 2'h0; // R12
					if (wd[1:0] == 2'h1 || wd[1:0] == 2'h2) begin
						for (int k = 0; k < 4; k++) begin
							n.pins.level[c][k] = s.ioc[c][4*k + `TPM_F_INIT]; // R4
						end
					end
				end
				`TPM_REG_IOC: n.ioc[c] = wd;
				`TPM_REG_IER: n.ier[c] = wd[5:0];
				default: begin
					ri = 2'(rs - `TPM_REG_CMPA);
					if (rs >= `TPM_REG_CMPA && rs < 4'(`TPM_REG_CMPA + 4'(nregs(c))))
						n.cmp[c][ri] = wd;
				end
				endcase
			end
			// a counter write reaches every channel of the synchronous group
			if (bus_req.wr && rs == `TPM_REG_CNT && ch < 3'h3 &&
				(ch == 3'(c) || (s.sync[c] && s.sync[ch[1:0]])))
				n.cnt[c] = wd; // R2
		end

		if (bus_req.wr && ch == `TPM_CH_GLOBAL && rs == `TPM_REG_START) begin
			n.start = wd[`TPM_F_START];
			n.sync = wd[`TPM_F_SYNC];
		end

		if (bus_req.rd && ch < 3'h3) begin
			case (rs)
			`TPM_REG_CTRL: n.rdata = {8'h00, s.ctrl[ch[1:0]]};
			`TPM_REG_IOC: n.rdata = s.ioc[ch[1:0]];
			`TPM_REG_IER: n.rdata = {10'h000, s.ier[ch[1:0]]};
			`TPM_REG_STAT: n.rdata = {8'h00, s.dir[ch[1:0]], 1'b0,
				s.flag[ch[1:0]]}; // R15
			`TPM_REG_CNT: n.rdata = s.cnt[ch[1:0]];
			default: begin
				ri = 2'(rs - `TPM_REG_CMPA);
				if (rs >= `TPM_REG_CMPA &&
					rs < 4'(`TPM_REG_CMPA + 4'(nregs(int'(ch)))))
					n.rdata = s.cmp[ch[1:0]][ri];
			end
			endcase
		end else if (bus_req.rd && ch == `TPM_CH_GLOBAL &&
			rs == `TPM_REG_START) begin
			n.rdata = {9'h000, s.sync, 1'b0, s.start};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '0;
			s.cmp <= {12{`TPM_RST_CMP}};
			s.dir <= 3'h7;
		end else begin
			s <= n;
		end
	end

	assign rdata = s.rdata;
	assign pins = s.pins;
	assign ovf_irq = {s.flag[2][`TPM_F_OVF] & s.ier[2][`TPM_F_OVF],
		s.flag[1][`TPM_F_OVF] & s.ier[1][`TPM_F_OVF],
		s.flag[0][`TPM_F_OVF] & s.ier[0][`TPM_F_OVF]};
	assign udf_irq = {s.flag[2][`TPM_F_UDF] & s.ier[2][`TPM_F_UDF],
		s.flag[1][`TPM_F_UDF] & s.ier[1][`TPM_F_UDF],
		s.flag[0][`TPM_F_UDF] & s.ier[0][`TPM_F_UDF]}; // R22

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence ch1_quiet;
		!clr[1] && !bus_req.wr;
	endsequence

	sequence ch1_var2_a_fall_b_high;
		md[1] == TPM_PHASE && s.ctrl[1][`TPM_F_PV] == 2'h1 && s.start[1] &&
		!s.s2[0] && s.prev[0] && s.s2[1];
	endsequence

	sequence ch0_pwm2_clear;
		md[0] == TPM_PWM2 && clr[0] && !bus_req.wr;
	endsequence

	phase_var2_up_a: assert property ( // R19
		ch1_var2_a_fall_b_high ##0 ch1_quiet |=>
		s.cnt[1] == $past(s.cnt[1]) + 16'h0001)
		else $error("variant 2 missed an up count");

	ovf_flag_a: assert property ( // R14
		up[1] && s.cnt[1] == `TPM_CNT_MAX && !clr[1] |=>
		s.flag[1][`TPM_F_OVF] && s.cnt[1] == `TPM_CNT_ZERO)
		else $error("overflow flag not set on wrap");

	udf_set_wins_a: assert property ( // R14
		dn[1] && s.cnt[1] == `TPM_CNT_ZERO && !clr[1] |=>
		s.flag[1][`TPM_F_UDF] && s.cnt[1] == `TPM_CNT_MAX)
		else $error("underflow flag lost or count wrong");

	udf_irq_drop_a: assert property ( // R22
		bus_req.wr && ch == 3'h1 && rs == `TPM_REG_STAT &&
		!wd[`TPM_F_UDF] && !(dn[1] && s.cnt[1] == `TPM_CNT_ZERO) |=>
		!udf_irq[1])
		else $error("underflow request did not drop on clear");

	udf_irq_rise_a: assert property ( // R22
		dn[1] && s.cnt[1] == `TPM_CNT_ZERO && !clr[1] &&
		s.ier[1][`TPM_F_UDF] && !bus_req.wr |=> udf_irq[1] [*2])
		else $error("underflow request not raised");

	ch0_no_phase_a: assert property ( // R12
		bus_req.wr && ch == 3'h0 && rs == `TPM_REG_CTRL |=>
		md[0] != TPM_PHASE)
		else $error("channel 0 entered phase counting");

	dir_down_a: assert property ( // R15
		dn[2] && !up[2] |=> !s.dir[2] ##0 s.cnt[2] != $past(s.cnt[2]))
		else $error("direction bit not down after down count");

	pwm2_init_a: assert property ( // R8
		ch0_pwm2_clear |=> pins.level[0][0] == $past(s.ioc[0][`TPM_F_INIT]) &&
		pins.level[0][1] == $past(s.ioc[0][4 + `TPM_F_INIT]) &&
		pins.level[0][2] == $past(s.ioc[0][8 + `TPM_F_INIT]) &&
		pins.level[0][3] == $past(s.ioc[0][12 + `TPM_F_INIT]))
		else $error("pwm2 clear did not restore initial levels");

	// a pwm1 entry loads pins A and C from their initial level bits
	pwm1_init_a: assert property ( // R4
		bus_req.wr && ch == 3'h0 && rs == `TPM_REG_CTRL && wd[1:0] == 2'h1 |=>
		pins.level[0][0] == $past(s.ioc[0][`TPM_F_INIT]) &&
		pins.level[0][2] == $past(s.ioc[0][8 + `TPM_F_INIT]))
		else $error("pwm1 entry did not load initial levels");

	pwm1_match_b_a: assert property ( // R3
		md[0] == TPM_PWM1 && hit[0][1] && !hit[0][0] &&
		s.cmp[0][0] != s.cmp[0][1] && s.ioc[0][5:4] == 2'h2 &&
		!bus_req.wr |=> pins.level[0][0])
		else $error("pwm1 match B did not drive pin A high");

	sync_clear_a: assert property ( // R10
		clr[0] && s.sync[0] && s.sync[1] &&
		s.ctrl[1][`TPM_F_CLR] == `TPM_CLR_SYNC && !bus_req.wr |=>
		s.cnt[1] == `TPM_CNT_ZERO)
		else $error("synchronous clear missed channel 1");

	pwm1_equal_a: assert property ( // R5
		md[0] == TPM_PWM1 && s.cmp[0][0] == s.cmp[0][1] && !bus_req.wr |=>
		$stable(pins.level[0][0]))
		else $error("pwm1 equal pair changed the pin");

	pwm2_cycle_pin_a: assert property ( // R7
		md[0] == TPM_PWM2 && s.ctrl[0][`TPM_F_CLR] == 3'h1 && !bus_req.wr |=>
		!pins.oe[0][0] && pins.oe[0][1] && pins.oe[0][3])
		else $error("pwm2 cycle pin enabled");

	pwm1_pin_b_a: assert property ( // R11
		md[0] == TPM_PWM1 && !bus_req.wr |=> !pins.oe[0][1] &&
		!pins.oe[0][3] && pins.oe[0][0] && pins.oe[0][2])
		else $error("pwm1 drives pin b or d");

endmodule : tpm_timer

// ### tpm_defs.svh
// tpm_defs.svh: offsets, field positions, reset values of the timer block
// assumes a word-indexed register port with the channel in addr bits 6:4
`ifndef TPM_DEFS_SVH
`define TPM_DEFS_SVH

`define TPM_CW 16
`define TPM_AW 7

// register index within a channel, addr[3:0]
`define TPM_REG_CTRL 4'h0
`define TPM_REG_IOC 4'h1
`define TPM_REG_IER 4'h2
`define TPM_REG_STAT 4'h3
`define TPM_REG_CNT 4'h4
`define TPM_REG_CMPA 4'h5

// global page, addr[6:4] == 3
`define TPM_CH_GLOBAL 3'h3
`define TPM_REG_START 4'h0

// control register fields
`define TPM_F_MODE 1:0
`define TPM_F_CLR 4:2
`define TPM_F_PV 6:5
`define TPM_CLR_NONE 3'h0
`define TPM_CLR_SYNC 3'h5

// output select nibble: bits 1:0 action, bit 2 initial level
`define TPM_F_INIT 2

// status and enable bit positions
`define TPM_F_OVF 4
`define TPM_F_UDF 5
`define TPM_F_DIR 7

// start register fields
`define TPM_F_START 2:0
`define TPM_F_SYNC 6:4

`define TPM_RST_CMP 16'hFFFF
`define TPM_CNT_MAX 16'hFFFF
`define TPM_CNT_ZERO 16'h0000

`endif

// ### tpm_pkg.sv
// tpm_pkg: types shared by the timer block
// assumes tpm_defs.svh is on the include path
`include "tpm_defs.svh"

package tpm_pkg;

	typedef enum logic [1:0] {
		TPM_NORMAL,
		TPM_PWM1,
		TPM_PWM2,
		TPM_PHASE
	} tpm_mode_t;

	typedef struct packed {
		logic [`TPM_AW-1:0] addr;
		logic [`TPM_CW-1:0] wdata;
		logic wr;
		logic rd;
	} tpm_bus_req_t;

	typedef struct packed {
		logic [2:0][3:0] level;
		logic [2:0][3:0] oe;
	} tpm_pins_t;

	typedef struct packed {
		logic [2:0][`TPM_CW-1:0] cnt;
		logic [2:0][3:0][`TPM_CW-1:0] cmp;
		logic [2:0][7:0] ctrl;
		logic [2:0][15:0] ioc;
		logic [2:0][5:0] ier;
		logic [2:0][5:0] flag;
		logic [2:0] dir;
		logic [2:0] start;
		logic [2:0] sync;
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] prev;
		tpm_pins_t pins;
		logic [`TPM_CW-1:0] rdata;
	} tpm_state_t;

endpackage : tpm_pkg

// ### tpm_enc_model.sv
// tpm_enc_model: quadrature encoder driving the four phase inputs
// assumes the timer samples the phase inputs on rising clk edges
`timescale 1ns/1ps

module tpm_enc_model (
	input wire logic clk,
	output logic [3:0] ext_clock_in
);
	logic [1:0] pos [2];

	initial begin
		ext_clock_in = 4'h0;
		pos = '{2'h0, 2'h0};
	end

	// n > 0 turns forward (A leads B); gap sets prompt or slow stepping
	task turn(input int ch, input int n, input int gap);
		int i;
		for (i = 0; i < (n < 0 ? -n : n); i++) begin
			pos[ch-1] = pos[ch-1] + (n < 0 ? 2'h3 : 2'h1);
			@(posedge clk);
			ext_clock_in[2*ch-2 +: 2] <= {pos[ch-1][1], ^pos[ch-1]};
			repeat (gap) @(posedge clk);
		end
	endtask : turn

endmodule : tpm_enc_model

// ### tb_timer_pwm_and_quadrature_modes.sv
// tb_timer_pwm_and_quadrature_modes: register-level tests of the timer
// assumes tpm_timer and tpm_enc_model; 40 MHz clock, sync reset
`timescale 1ns/1ps

module tb_timer_pwm_and_quadrature_modes import tpm_pkg::*;;
	logic clk = 1'b0;
	logic reset = 1'b1;
	tpm_bus_req_t bus_req = '0;
	logic [15:0] rdata;
	logic [3:0] ext_clock_in;
	tpm_pins_t pins;
	logic [2:0] ovf_irq;
	logic [2:0] udf_irq;
	int miscompares = 0;
	int n_compared = 0;
	// counts per full encoder cycle for variants 1..4
	logic [15:0] kv [4] = '{16'h0004, 16'h0001, 16'h0001, 16'h0002};
	int v;

	always #12.5 clk = ~clk;

	tpm_timer i_dut (
		.clk(clk),
		.reset(reset),
		.bus_req(bus_req),
		.rdata(rdata),
		.ext_clock_in(ext_clock_in),
		.pins(pins),
		.ovf_irq(ovf_irq),
		.udf_irq(udf_irq)
	);

	tpm_enc_model i_enc (
		.clk(clk),
		.ext_clock_in(ext_clock_in)
	);

	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge clk);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask : wr

	task chk_rd(input string nm, input logic [6:0] a, input logic [15:0] m,
		input logic [15:0] e);
		@(posedge clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1;
		chk(nm, e, rdata & m);
	endtask : chk_rd

	// counts high cycles of one pin over ten periods of ten clocks
	task chk_high(input string nm, input int c, input int k,
		input logic [15:0] e);
		logic [15:0] h;
		h = 16'h0000;
		repeat (100) begin
			@(posedge clk);
			#1;
			h = h + 16'(pins.level[c][k]);
		end
		chk(nm, e, h);
	endtask : chk_high

	// channel 0 pwm: period from compare A = 9, counter restarted at 0
	task pwm(input logic [15:0] ctrl, input logic [15:0] ioc,
		input logic [15:0] cb, input logic [15:0] cd);
		wr(7'h30, 16'h0000);
		wr(7'h05, 16'h0009);
		wr(7'h06, cb);
		wr(7'h08, cd);
		wr(7'h01, ioc);
		wr(7'h04, 16'h0000);
		wr(7'h00, ctrl);
		wr(7'h30, 16'h0001);
		repeat (20) @(posedge clk);
		#1;
	endtask : pwm

	task end_of_test;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		end_of_test();
	end

	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		chk_rd("cmp_a0", 7'h05, 16'hFFFF, 16'hFFFF);
		chk_rd("stat1", 7'h13, 16'hFFFF, 16'h0080);
		chk_rd("cmp_c1", 7'h17, 16'hFFFF, 16'h0000);
		wr(7'h00, 16'h0003);
		chk_rd("ctrl0", 7'h00, 16'hFFFF, 16'h0000);
		$display("test regs done");
		pwm(16'h0005, 16'h0021, 16'h0003, 16'hFFFF);
		chk("oe_pwm1", 16'h0001, {14'h0, pins.oe[0][1:0]});
		chk_high("pin_a_lh", 0, 0, 16'h003C);
		pwm(16'h0005, 16'h0033, 16'h0003, 16'hFFFF);
		chk_high("pin_a_tg", 0, 0, 16'h003C);
		pwm(16'h0005, 16'h0025, 16'h0009, 16'hFFFF);
		chk_high("pin_a_eq", 0, 0, 16'h0064);
		$display("test pwm1 done");
		pwm(16'h0006, 16'h5020, 16'h0003, 16'h0009);
		chk("oe_pwm2", 16'h0002, {14'h0, pins.oe[0][1:0]});
		chk_high("pin_b", 0, 1, 16'h003C);
		chk_high("pin_d", 0, 3, 16'h0064);
		// channel 1 pwm2 pin A, cleared with channel 0 through the sync group
		wr(7'h15, 16'h0005);
		wr(7'h11, 16'h0002);
		wr(7'h10, 16'h0016);
		wr(7'h30, 16'h0030);
		wr(7'h04, 16'h0000);
		wr(7'h30, 16'h0033);
		chk_high("pin_a1_sync", 1, 0, 16'h0028);
		$display("test pwm2 done");
		wr(7'h30, 16'h0002);
		for (v = 0; v < 4; v++) begin
			wr(7'h10, 16'h0003 | 16'(v << 5));
			wr(7'h14, 16'h0100);
			i_enc.turn(1, 8, 4);
			chk_rd("cnt_up", 7'h14, 16'hFFFF, 16'h0100 + (kv[v] << 1));
			chk_rd("dir_up", 7'h13, 16'h0080, 16'h0080);
			i_enc.turn(1, -12, 12);
			chk_rd("cnt_dn", 7'h14, 16'hFFFF, 16'h0100 - kv[v]);
			chk_rd("dir_dn", 7'h13, 16'h0080, 16'h0000);
		end
		$display("test phase done");
		wr(7'h10, 16'h0003);
		wr(7'h12, 16'h0030);
		wr(7'h14, 16'h0000);
		i_enc.turn(1, -1, 4);
		chk_rd("stat_udf", 7'h13, 16'h00F0, 16'h0020);
		chk("udf_irq", 16'h0001, {15'h0, udf_irq[1]});
		wr(7'h13, 16'h0000);
		@(posedge clk);
		#1;
		chk("udf_clr", 16'h0000, {15'h0, udf_irq[1]});
		wr(7'h14, 16'hFFFF);
		i_enc.turn(1, 1, 4);
		chk_rd("stat_ovf", 7'h13, 16'h00F0, 16'h0090);
		chk("ovf_irq", 16'h0001, {15'h0, ovf_irq[1]});
		wr(7'h20, 16'h0003);
		wr(7'h24, 16'h0100);
		wr(7'h30, 16'h0004);
		i_enc.turn(2, 4, 4);
		chk_rd("cnt_ch2", 7'h24, 16'hFFFF, 16'h0104);
		i_enc.turn(2, -4, 4);
		chk_rd("cnt_ch2_dn", 7'h24, 16'hFFFF, 16'h0100);
		chk("oe_ch1_cd", 16'h0000, {14'h0, pins.oe[1][3:2]});
		$display("test flags done");
		end_of_test();
	end

endmodule : tb_timer_pwm_and_quadrature_modes
